/* File: pwmoc_top.v */
// pwm module: four generators, output conditioning and module interrupt status
`timescale 1ns/1ps
`default_nettype none
`include "pwmoc_regs.vh"

// Summary of operation
// - Each generator period is the programmed number of clock ticks between zero pulses, one tick when the programmed value is zero.
// - Four independent generators, numbered zero to three, each have their own period.
// - A period write made before the pending update is applied replaces the pending value.
// - Period readback gives the last programmed value, even if not yet in use.
// - Eight interrupt enable bits, one per generator and per fault, unmask when set.
// - Both raw and masked interrupt status are shown, masked gated by the enables.
// - Outputs with fault suppress set go to a fixed level during fault zero, or any fault with extended handling, others keep running.
// - Without extended fault handling or configured level, suppressed outputs drive low.
// - With extended fault handling a per-output level picks high or low when suppressed.
// - The fault level has no effect on outputs that are not fault suppressed.
// - A per-output polarity flip makes the output active low, otherwise active high.
// - A per-output enable passes the raw pwm signal to the output, else inactive.
// - Each output has an update mode that sets when enable changes take effect.
// - Immediate mode applies at once, local mode at the owner generator's next zero.
// - Global mode applies at the next zero after a sync update naming the generator.
module pwmoc_top #(
    parameter CNT_W = `PWMOC_CNT_W
) (
    // clock and reset
    input  wire                 sys_clk_in,
    input  wire                 rst_b_in,
    // period programming, one strobe per generator
    input  wire [3:0]           period_wr_in,
    input  wire [CNT_W-1:0]     period_data_in,
    output wire [4*CNT_W-1:0]   period_rd_out,
    // synchronous update command, one bit per generator
    input  wire [3:0]           sync_upd_in,
    // generator zero-count pulses
    output reg  [3:0]           gen_zero_out,
    // per-output controls
    input  wire [7:0]           pwm_raw_in,
    input  wire [7:0]           output_enable_flag_in,
    input  wire [7:0]           output_polarity_flip_in,
    input  wire [7:0]           fault_suppress_flag_in,
    input  wire [7:0]           fault_level_high_flag_in,
    input  wire [15:0]          output_update_mode_in,
    input  wire                 ext_fault_en_in,
    // fault inputs
    input  wire [3:0]           fault_in,
    // interrupt control and status
    input  wire [7:0]           int_en_in,
    input  wire [7:0]           int_clr_in,
    output reg  [7:0]           int_raw_out,
    output reg  [7:0]           int_masked_out,
    output reg                  irq_out,
    // pwm pins
    output reg  [7:0]           pwm_out
);

    wire [3:0]  zero;
    wire [7:0]  en_act;
    wire [7:0]  events;
    wire        fault_act;
    reg  [7:0]  nxt_int_raw;
    reg  [7:0]  nxt_pwm;
    integer     k;

    // ****************************************
    // generators
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < `PWMOC_NUM_GEN; g = g + 1) begin : gen_blk
            pwmoc_gen #(
                .CNT_W (CNT_W)
            ) u_gen (
                .sys_clk_in     (sys_clk_in),
                .rst_b_in       (rst_b_in),
                .period_wr_in   (period_wr_in[g]),
                .period_data_in (period_data_in),
                .period_prog_ff (period_rd_out[g*CNT_W +: CNT_W]),
                .sync_upd_in    (sync_upd_in[g]),
                .en_req_in      (output_enable_flag_in[2*g +: 2]),
                .mode_in        (output_update_mode_in[4*g +: 4]),
                .en_act_ff      (en_act[2*g +: 2]),
                .zero_out       (zero[g])
            );
        end
    endgenerate

    // ****************************************
    // fault condition
    // ****************************************
    // basic handling watches fault zero only
    assign fault_act = ext_fault_en_in ? (|fault_in) : fault_in[0];

    // ****************************************
    // output conditioning
    // ****************************************
    always @* begin
        nxt_pwm = `PWMOC_OUT_RST;
        for (k = 0; k < `PWMOC_NUM_OUT; k = k + 1) begin
            nxt_pwm[k] = (pwm_raw_in[k] & en_act[k]) ^ output_polarity_flip_in[k];
            if (fault_act && fault_suppress_flag_in[k]) begin
                nxt_pwm[k] = ext_fault_en_in & fault_level_high_flag_in[k];
            end
        end
    end

    // ****************************************
    // interrupt status
    // ****************************************
    assign events = {fault_in, zero};

    always @* begin
        // set wins over clear
        nxt_int_raw = (int_raw_out & ~int_clr_in) | events;
    end

    always @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            int_raw_out    <= `PWMOC_INT_RST;
            int_masked_out <= `PWMOC_INT_RST;
            irq_out        <= 1'b0;
            gen_zero_out   <= 4'h0;
            pwm_out        <= `PWMOC_OUT_RST;
        end else begin
            int_raw_out    <= nxt_int_raw;
            int_masked_out <= nxt_int_raw & int_en_in;
            irq_out        <= |(nxt_int_raw & int_en_in);
            gen_zero_out   <= zero;
            pwm_out        <= nxt_pwm;
        end
    end

endmodule
`default_nettype wire

/* File: pwmoc_regs.vh */
// constants for the pwm output and period control block
`ifndef PWMOC_REGS_VH
`define PWMOC_REGS_VH

// ****************************************
// widths and counts
// ****************************************
`define PWMOC_NUM_GEN        4
`define PWMOC_NUM_OUT        8
`define PWMOC_NUM_FAULT      4
`define PWMOC_CNT_W          16

// ****************************************
// reset values
// ****************************************
`define PWMOC_PERIOD_RST     16'h0000
`define PWMOC_INT_RST        8'h00
`define PWMOC_OUT_RST        8'h00

// ****************************************
// output update modes
// ****************************************
`define PWMOC_MODE_IMMED     2'h0
`define PWMOC_MODE_LOCAL     2'h1
`define PWMOC_MODE_GLOBAL    2'h2

// ****************************************
// interrupt status field positions
// ****************************************
`define PWMOC_INT_GEN_LSB    0
`define PWMOC_INT_FAULT_LSB  4

`endif

/* File: pwmoc_gen.v */
// one pwm generator: period counter, pending period and enable update timing
`timescale 1ns/1ps
`default_nettype none
`include "pwmoc_regs.vh"

module pwmoc_gen #(
    parameter CNT_W = `PWMOC_CNT_W
) (
    // clock and reset
    input  wire             sys_clk_in,
    input  wire             rst_b_in,
    // period programming
    input  wire             period_wr_in,
    input  wire [CNT_W-1:0] period_data_in,
    output reg  [CNT_W-1:0] period_prog_ff,
    // synchronous update command
    input  wire             sync_upd_in,
    // enable requests and modes for the two outputs
    input  wire [1:0]       en_req_in,
    input  wire [3:0]       mode_in,
    output reg  [1:0]       en_act_ff,
    // zero-count pulse
    output wire             zero_out
);

    reg  [CNT_W-1:0] cnt_ff;
    reg  [CNT_W-1:0] period_act_ff;
    reg              armed_ff;
    reg  [1:0]       nxt_en_act;
    wire             wrap;
    integer          i;

    // ****************************************
    // period counter
    // ****************************************
    assign zero_out = (cnt_ff == {CNT_W{1'b0}});
    assign wrap     = (period_act_ff == {CNT_W{1'b0}}) ||
                      (cnt_ff >= period_act_ff - {{(CNT_W-1){1'b0}}, 1'b1});

    always @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            cnt_ff         <= {CNT_W{1'b0}};
            period_act_ff  <= `PWMOC_PERIOD_RST;
            period_prog_ff <= `PWMOC_PERIOD_RST;
            armed_ff       <= 1'b0;
            en_act_ff      <= 2'b00;
        end else begin
            if (wrap) begin
                cnt_ff <= {CNT_W{1'b0}};
                period_act_ff <= period_prog_ff;
            end else begin
                cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            if (period_wr_in) begin
                period_prog_ff <= period_data_in;
            end
            if (sync_upd_in) begin
                armed_ff <= 1'b1;
            end else if (wrap) begin
                armed_ff <= 1'b0;
            end
            en_act_ff <= nxt_en_act;
        end
    end

    // ****************************************
    // enable update timing
    // ****************************************
    always @* begin
        nxt_en_act = en_act_ff;
        for (i = 0; i < 2; i = i + 1) begin
            case (mode_in[2*i +: 2])
                `PWMOC_MODE_IMMED: begin
                    nxt_en_act[i] = en_req_in[i];
                end
                `PWMOC_MODE_LOCAL: begin
                    if (wrap) begin
                        nxt_en_act[i] = en_req_in[i];
                    end
                end
                `PWMOC_MODE_GLOBAL: begin
                    if (wrap && armed_ff) begin
                        nxt_en_act[i] = en_req_in[i];
                    end
                end
                default: begin
                    nxt_en_act[i] = en_req_in[i];
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* File: pwmoc_chk_sva.sv */
// port assertions for the pwm output and period control block
`timescale 1ns/1ps
`default_nettype none
module pwmoc_chk (
    input wire logic       sys_clk_in,
    input wire logic       rst_b_in,
    input wire logic [3:0] gen_zero_out,
    input wire logic [7:0] pwm_raw_in,
    input wire logic [7:0] output_polarity_flip_in,
    input wire logic [7:0] fault_suppress_flag_in,
    input wire logic [7:0] fault_level_high_flag_in,
    input wire logic       ext_fault_en_in,
    input wire logic [3:0] fault_in,
    input wire logic [7:0] pwm_out,
    input wire logic [7:0] int_en_in,
    input wire logic [7:0] int_clr_in,
    input wire logic [7:0] int_raw_out,
    input wire logic [7:0] int_masked_out,
    input wire logic       irq_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_clr5;
        int_clr_in[5] && !fault_in[1];
    endsequence
    AST_SUP: assert property (
        (fault_in[0] && fault_suppress_flag_in[0] && !ext_fault_en_in) |=> !pwm_out[0])
        else $error("suppressed pin high");
    AST_LVL: assert property (
        (ext_fault_en_in && |fault_in && fault_suppress_flag_in[1])
        |=> pwm_out[1] == $past(fault_level_high_flag_in[1])) else $error("bad fault level");
    AST_PASS: assert property (
        (!fault_suppress_flag_in[2] && output_polarity_flip_in[2] && !pwm_raw_in[2])
        |=> pwm_out[2]) else $error("flipped pin low");
    AST_FLT: assert property (fault_in[1] |=> int_raw_out[5]) else $error("no fault bit");
    AST_CLR: assert property (s_clr5 |=> !int_raw_out[5]) else $error("not cleared");
    AST_ZERO: assert property (gen_zero_out[0] |-> int_raw_out[0]) else $error("no gen bit");
    AST_MASK: assert property (
        int_masked_out == (int_raw_out & $past(int_en_in))) else $error("bad mask");
    AST_IRQ: assert property (irq_out == |int_masked_out) else $error("bad irq");
endmodule
bind pwmoc_top pwmoc_chk i_chk (.sys_clk_in, .rst_b_in, .gen_zero_out, .pwm_raw_in,
    .output_polarity_flip_in, .fault_suppress_flag_in, .fault_level_high_flag_in,
    .ext_fault_en_in, .fault_in, .pwm_out, .int_en_in, .int_clr_in, .int_raw_out,
    .int_masked_out, .irq_out);
`default_nettype wire

/* File: pwmoc_load.sv */
// load model seen by the pwm pins
`timescale 1ns/1ps
`default_nettype none
module pwmoc_load (
    input  wire logic       sys_clk_in,
    input  wire logic [7:0] pwm_in,
    output var  logic [7:0] load_level_out
);
    always_ff @(posedge sys_clk_in) begin
        load_level_out <= pwm_in;
    end
endmodule
`default_nettype wire

/* File: tb_pwm_output_and_period_control.sv */
// self-checking bench for the pwm output and period control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_pwm_output_and_period_control;
    logic        sys_clk_in, rst_b_in, ext_fault_en_in;
    logic [3:0]  period_wr_in, sync_upd_in, fault_in;
    logic [15:0] period_data_in, output_update_mode_in;
    logic [7:0]  pwm_raw_in, output_enable_flag_in, output_polarity_flip_in, int_en_in;
    logic [7:0]  fault_suppress_flag_in, fault_level_high_flag_in, int_clr_in;
    wire  [63:0] period_rd_out;
    wire  [7:0]  int_raw_out, int_masked_out, pwm_out;
    wire  [3:0]  gen_zero_out;
    wire         irq_out;
    wire  [7:0]  load_level;
    int          err_count = 0, check_count = 0;
    // rows: raw, enable, flip, suppress, level, {ext, fault}, expected pins
    logic [55:0] rows [7] = '{56'hF0FF00000000F0, 56'hF00F0000000000, 56'hF0FF3C000000CC,
        56'hFFFF000FFF01F0, 56'hFFFF000F0511F5, 56'h00FF500FF31453, 56'hFFFF00FFFF02FF};
    pwmoc_top i_dut (.sys_clk_in, .rst_b_in, .period_wr_in, .period_data_in, .period_rd_out,
        .sync_upd_in, .gen_zero_out, .pwm_raw_in, .output_enable_flag_in,
        .output_polarity_flip_in, .fault_suppress_flag_in, .fault_level_high_flag_in,
        .output_update_mode_in, .ext_fault_en_in, .fault_in, .int_en_in, .int_clr_in,
        .int_raw_out, .int_masked_out, .irq_out, .pwm_out);
    pwmoc_load i_load (.sys_clk_in, .pwm_in(pwm_out), .load_level_out(load_level));
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    task automatic stop_test();
        if (err_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic zw(input int g);
        for (int n = 0; n < 40 && gen_zero_out[g] !== 1'b1; n++) wt(1);
    endtask
    task automatic per(input int g, input int p);
        int n;
        zw(g);
        wt(1);
        for (n = 1; n < 40 && gen_zero_out[g] !== 1'b1; n++) wt(1);
        `CHK(n, p)
    endtask
    task automatic wr(input int g, input logic [15:0] v);
        wt(1);
        period_wr_in <= 4'h1 << g;
        period_data_in <= v;
        wt(1);
        period_wr_in <= 4'h0;
    endtask
    task automatic pin(input int n, input logic v);
        wt(n);
        `CHK(pwm_out[0], v)
    endtask
    initial begin
        {rst_b_in, ext_fault_en_in, period_wr_in, sync_upd_in, fault_in, period_data_in} = '0;
        {output_update_mode_in, pwm_raw_in, output_enable_flag_in, int_en_in, int_clr_in} = '0;
        {output_polarity_flip_in, fault_suppress_flag_in, fault_level_high_flag_in} = '0;
        wt(12);
        rst_b_in <= 1'b1;
        `CHK({pwm_out, int_raw_out, period_rd_out}, 80'h0)
        foreach (rows[i]) begin
            wt(1);
            {pwm_raw_in, output_enable_flag_in, output_polarity_flip_in, fault_suppress_flag_in,
                fault_level_high_flag_in} <= rows[i][55:16];
            {ext_fault_en_in, fault_in} <= rows[i][12:8];
            wt(4);
            `CHK(pwm_out, rows[i][7:0])
            `CHK(load_level, rows[i][7:0])
        end
        for (int g = 0; g < 4; g++) wr(g, 16'(12 - g));
        zw(1);
        wr(1, 16'h0014);
        wr(1, 16'h0007);
        wt(1);
        `CHK(period_rd_out, 64'h0009_000A_0007_000C)
        wt(15);
        for (int g = 0; g < 4; g++) per(g, (g == 1) ? 7 : 12 - g);
        fault_in <= 4'h0;
        output_update_mode_in <= 16'h0001;
        zw(0);
        output_enable_flag_in <= 8'hFE;
        pin(4, 1'b1);
        zw(0);
        pin(3, 1'b0);
        output_update_mode_in <= 16'h0002;
        output_enable_flag_in <= 8'hFF;
        pin(4, 1'b0);
        zw(0);
        pin(3, 1'b0);
        sync_upd_in <= 4'h1;
        wt(1);
        sync_upd_in <= 4'h0;
        zw(0);
        pin(3, 1'b1);
        output_update_mode_in <= 16'h0003;
        output_enable_flag_in <= 8'hFE;
        pin(3, 1'b0);
        int_clr_in <= 8'hFF;
        int_en_in <= 8'h20;
        wt(1);
        int_clr_in <= 8'h00;
        fault_in <= 4'h2;
        wt(1);
        fault_in <= 4'h0;
        wt(1);
        `CHK({int_raw_out[5], int_masked_out, irq_out}, 10'h241)
        int_en_in <= 8'h00;
        wt(2);
        `CHK({int_raw_out[5], int_masked_out, irq_out}, 10'h200)
        int_clr_in <= 8'h20;
        wt(1);
        int_clr_in <= 8'h00;
        wt(1);
        `CHK(int_raw_out[5], 1'b0)
        int_en_in <= 8'h0F;
        wt(13);
        `CHK({int_raw_out, int_masked_out, irq_out}, 17'h01E1F)
        rst_b_in <= 1'b0;
        wt(2);
        `CHK({pwm_out, int_raw_out, int_masked_out, irq_out, gen_zero_out}, 29'h0)
        `CHK(period_rd_out, 64'h0)
        rst_b_in <= 1'b1;
        wt(2);
        `CHK(period_rd_out, 64'h0)
        stop_test();
    end
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
